// ==== hdl/mtsr_defs.vh ====
// Constants for the transmit statistics and receive control block
// Functional notes
// - Pulse one size-bin increment per sent packet of 2048-4095, 4096-8191, 8192-9215 bytes.
// - Packets under 64 bytes pulse undersize and are never put on the line.
// - Packets presented longer than 9215 bytes pulse the oversize increment.
// - Sent packets over 64 bytes with a bad FCS pulse transmit bad-FCS.
// - Packets whose end the user marked aborted pulse the frame-error increment.
// - Local fault stays 1 while the decoder state machine sits in its init state.
// - Transmit FIFO error goes 1 when the clock-compensation FIFO under- or overflows.
// - Receive expects lane markers every spacing plus one words; spacing defaults 16383.
// - Test-pattern checking at 1 enters test mode and checks scrambled idle.
// - Receive enable at 0 ends current packet, stops decoding, statistics and user output.
// - FCS deletion at 1 strips the FCS, never from packets of 8 bytes or less.
// - With FCS ignoring at 0, a bad FCS raises the error on the final transfer.
// - Ignored FCS errors count the packet as good but still pulse receive bad-FCS.
`ifndef MTSR_DEFS_VH
`define MTSR_DEFS_VH
// Register byte offsets
`define MTSR_OFF_CTRL      8'h00
`define MTSR_OFF_SPACING   8'h04
`define MTSR_OFF_STATUS    8'h08
`define MTSR_OFF_INT_STAT  8'h0C
`define MTSR_OFF_INT_MASK  8'h10
`define MTSR_OFF_TP_ERRS   8'h14
// Control register fields
`define MTSR_CTRL_RX_EN    0
`define MTSR_CTRL_TEST     1
`define MTSR_CTRL_DEL_FCS  2
`define MTSR_CTRL_IGN_FCS  3
`define MTSR_CTRL_RX_RST   4
`define MTSR_CTRL_RST      5'h01
`define MTSR_SPACING_RST   16'h3FFF
// Interrupt status and mask fields
`define MTSR_INT_FIFO      0
`define MTSR_INT_MARKER    1
`define MTSR_INT_TP        2
`define MTSR_INT_RX_FCS    3
`define MTSR_INT_RST       4'h0
// Packet length limits in bytes
`define MTSR_LEN_MIN       14'd64
`define MTSR_LEN_B2048     14'd2048
`define MTSR_LEN_B4096     14'd4096
`define MTSR_LEN_B8192     14'd8192
`define MTSR_LEN_MAX       14'd9215
`define MTSR_LEN_NOSTRIP   14'd8
// Clock-compensation FIFO depth in words
`define MTSR_CC_DEPTH      5'd16
`endif

// ==== hdl/mtsr_core.v ====
// Transmit statistics, receive control and register slave of the Ethernet MAC
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`include "mtsr_defs.vh"
module mtsr_core (
   input  wire        sys_clk,
   input  wire        reset,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [31:0] hrdata,
   output reg         irq,
   // Transmit packet report, one pulse per packet end
   input  wire        tx_pkt_end,
   input  wire [13:0] tx_pkt_len,
   input  wire        tx_pkt_fcs_err,
   input  wire        tx_pkt_abort,
   output reg         tx_pkt_send,
   output reg         tx_pkt_drop,
   output reg         stat_tx_pkt_2048_4095,
   output reg         stat_tx_pkt_4096_8191,
   output reg         stat_tx_pkt_8192_9215,
   output reg         stat_tx_pkt_small,
   output reg         stat_tx_pkt_large,
   output reg         stat_tx_bad_fcs,
   output reg         stat_tx_frame_error,
   // Transmit lane and clock-compensation FIFO
   input  wire        tx_lane_ready,
   input  wire        cc_push,
   input  wire        cc_pop,
   output reg         stat_tx_local_fault,
   output reg         stat_tx_fifo_error,
   // Receive lane marker and test pattern inputs
   input  wire        rx_word_valid,
   input  wire        rx_word_is_marker,
   input  wire        rx_tp_valid,
   input  wire        rx_tp_idle_ok,
   output reg         rx_decode_en,
   output reg         rx_test_mode,
   // Receive byte stream from the decoder
   input  wire        rx_in_valid,
   input  wire [7:0]  rx_in_data,
   input  wire        rx_in_eop,
   input  wire        rx_in_fcs_bad,
   output reg         rx_in_ready,
   // Receive user interface
   output reg         rx_out_valid,
   output reg  [7:0]  rx_out_data,
   output reg         rx_out_sop,
   output reg         rx_out_eop,
   output reg         rx_out_err,
   output reg         stat_rx_good_pkt,
   output reg         stat_rx_bad_fcs
);

   localparam [1:0] ST_INIT = 2'b01;
   localparam [1:0] ST_RUN  = 2'b10;

   reg  [4:0]  ctrl_r;
   reg  [15:0] spacing_r;
   reg  [15:0] spacing_q_r;
   reg         del_fcs_q_r;
   reg  [3:0]  int_stat_r;
   reg  [3:0]  int_mask_r;
   reg  [15:0] tp_errs_r;
   reg         wr_pend_r;
   reg         rd_pend_r;
   reg  [7:0]  bus_addr_r;
   reg  [1:0]  dec_state_r;
   reg  [1:0]  dec_state_nxt;
   reg  [4:0]  cc_level_r;
   reg  [16:0] mk_cnt_r;
   reg         mk_lock_r;
   reg         mk_err_ev_r;
   reg         tp_err_ev_r;
   reg         en_eff_r;
   reg         in_pkt_r;
   reg  [13:0] rx_len_r;
   reg  [7:0]  dl_r [0:3];
   reg  [2:0]  dl_fill_r;
   reg         drain_r;
   reg         out_started_r;
   reg         err_pend_r;
   reg  [31:0] rd_mux;
   reg  [3:0]  int_ev;
   integer     i;

   wire        bus_take  = hsel & htrans[1] & hready;
   wire        rx_rst    = ctrl_r[`MTSR_CTRL_RX_RST];
   wire        ignore    = ctrl_r[`MTSR_CTRL_IGN_FCS];
   wire        wr_ctrl   = wr_pend_r & (bus_addr_r == `MTSR_OFF_CTRL);
   wire        wr_clear  = wr_pend_r & (bus_addr_r == `MTSR_OFF_INT_STAT);
   wire        cc_over   = cc_push & ~cc_pop & (cc_level_r == `MTSR_CC_DEPTH);
   wire        cc_under  = cc_pop & ~cc_push & (cc_level_r == 5'h00);
   wire [16:0] mk_expect = {1'b0, spacing_q_r} + 17'h00001;
   wire        rx_acc    = rx_in_valid & rx_in_ready;
   wire        eop_acc   = rx_acc & rx_in_eop;
   wire [13:0] len_total = rx_len_r + 14'h0001;
   // Short packets keep their FCS
   wire        strip     = del_fcs_q_r & (len_total > `MTSR_LEN_NOSTRIP);
   wire        start_dr  = eop_acc & ~strip;
   wire        drain_end = drain_r & (dl_fill_r == 3'h1);
   wire        drain_nxt = start_dr | (drain_r & ~drain_end);
   wire        in_pkt_nxt = (in_pkt_r | rx_acc) & ~eop_acc & ~rx_rst;
   wire        en_eff_nxt = in_pkt_r ? en_eff_r : ctrl_r[`MTSR_CTRL_RX_EN];

   // Bus address phase and wait state for reads
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wr_pend_r  <= 1'b0;
         rd_pend_r  <= 1'b0;
         bus_addr_r <= 8'h00;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         hrdata     <= 32'h00000000;
      end else begin
         wr_pend_r <= bus_take & hwrite;
         rd_pend_r <= bus_take & ~hwrite;
         if (bus_take) begin
            bus_addr_r <= haddr[7:0];
         end
         // Reads wait one cycle so a write just before is visible
         hreadyout <= ~(bus_take & ~hwrite);
         if (rd_pend_r) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Read data selection, unmapped reads give zero
   always @* begin
      rd_mux = 32'h00000000;
      if (bus_addr_r == `MTSR_OFF_CTRL) begin
         rd_mux[4:0] = ctrl_r;
      end else if (bus_addr_r == `MTSR_OFF_SPACING) begin
         rd_mux[15:0] = spacing_r;
      end else if (bus_addr_r == `MTSR_OFF_STATUS) begin
         rd_mux[3:0] = {rx_test_mode, rx_decode_en, stat_tx_fifo_error, stat_tx_local_fault};
      end else if (bus_addr_r == `MTSR_OFF_INT_STAT) begin
         rd_mux[3:0] = int_stat_r;
      end else if (bus_addr_r == `MTSR_OFF_INT_MASK) begin
         rd_mux[3:0] = int_mask_r;
      end else if (bus_addr_r == `MTSR_OFF_TP_ERRS) begin
         rd_mux[15:0] = tp_errs_r;
      end
   end

   // Register writes in the data phase
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ctrl_r     <= `MTSR_CTRL_RST;
         spacing_r  <= `MTSR_SPACING_RST;
         int_mask_r <= `MTSR_INT_RST;
      end else if (wr_pend_r) begin
         if (bus_addr_r == `MTSR_OFF_CTRL) begin
            ctrl_r <= hwdata[4:0];
         end else if (bus_addr_r == `MTSR_OFF_SPACING) begin
            spacing_r <= hwdata[15:0];
         end else if (bus_addr_r == `MTSR_OFF_INT_MASK) begin
            int_mask_r <= hwdata[3:0];
         end
      end
   end

   // Settings taken only under receive reset
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         spacing_q_r <= `MTSR_SPACING_RST;
         del_fcs_q_r <= 1'b0;
      end else if (rx_rst) begin
         spacing_q_r <= spacing_r;
         del_fcs_q_r <= ctrl_r[`MTSR_CTRL_DEL_FCS];
      end
   end

   // Interrupt events, a new event beats a write-one clear
   always @* begin
      int_ev = 4'h0;
      int_ev[`MTSR_INT_FIFO]   = cc_over | cc_under;
      int_ev[`MTSR_INT_MARKER] = mk_err_ev_r;
      int_ev[`MTSR_INT_TP]     = tp_err_ev_r;
      int_ev[`MTSR_INT_RX_FCS] = eop_acc & rx_in_fcs_bad;
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         int_stat_r <= `MTSR_INT_RST;
         irq        <= 1'b0;
      end else begin
         int_stat_r <= (int_stat_r & ~(wr_clear ? hwdata[3:0] : 4'h0)) | int_ev;
         irq        <= |(int_stat_r & int_mask_r);
      end
   end

   // Transmit packet classification, all pulses one cycle
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tx_pkt_send           <= 1'b0;
         tx_pkt_drop           <= 1'b0;
         stat_tx_pkt_2048_4095 <= 1'b0;
         stat_tx_pkt_4096_8191 <= 1'b0;
         stat_tx_pkt_8192_9215 <= 1'b0;
         stat_tx_pkt_small     <= 1'b0;
         stat_tx_pkt_large     <= 1'b0;
         stat_tx_bad_fcs       <= 1'b0;
         stat_tx_frame_error   <= 1'b0;
      end else begin
         // Runts counted and kept off the line
         tx_pkt_drop       <= tx_pkt_end & (tx_pkt_len < `MTSR_LEN_MIN);
         tx_pkt_send       <= tx_pkt_end & (tx_pkt_len >= `MTSR_LEN_MIN);
         stat_tx_pkt_small <= tx_pkt_end & (tx_pkt_len < `MTSR_LEN_MIN);
         stat_tx_pkt_2048_4095 <= tx_pkt_end & (tx_pkt_len >= `MTSR_LEN_B2048) &
                                  (tx_pkt_len < `MTSR_LEN_B4096);
         stat_tx_pkt_4096_8191 <= tx_pkt_end & (tx_pkt_len >= `MTSR_LEN_B4096) &
                                  (tx_pkt_len < `MTSR_LEN_B8192);
         stat_tx_pkt_8192_9215 <= tx_pkt_end & (tx_pkt_len >= `MTSR_LEN_B8192) &
                                  (tx_pkt_len <= `MTSR_LEN_MAX);
         stat_tx_pkt_large <= tx_pkt_end & (tx_pkt_len > `MTSR_LEN_MAX);
         stat_tx_bad_fcs <= tx_pkt_end & tx_pkt_fcs_err & (tx_pkt_len > `MTSR_LEN_MIN);
         // User abort at end of packet
         stat_tx_frame_error <= tx_pkt_end & tx_pkt_abort;
      end
   end

   // Decoder state machine next state
   always @* begin
      dec_state_nxt = dec_state_r;
      case (dec_state_r)
         ST_INIT: begin
            if (tx_lane_ready) begin
               dec_state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!tx_lane_ready) begin
               dec_state_nxt = ST_INIT;
            end
         end
         default: begin
            dec_state_nxt = ST_INIT;
         end
      endcase
   end

   // Decoder state and clock-compensation FIFO level
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dec_state_r         <= ST_INIT;
         stat_tx_local_fault <= 1'b1;
         cc_level_r          <= 5'h00;
         stat_tx_fifo_error  <= 1'b0;
      end else begin
         dec_state_r <= dec_state_nxt;
         stat_tx_local_fault <= (dec_state_nxt == ST_INIT);
         if (cc_push & ~cc_pop & ~cc_over) begin
            cc_level_r <= cc_level_r + 5'h01;
         end else if (cc_pop & ~cc_push & ~cc_under) begin
            cc_level_r <= cc_level_r - 5'h01;
         end
         // Sticky until the port is reset
         if (cc_over | cc_under) begin
            stat_tx_fifo_error <= 1'b1;
         end
      end
   end

   // Lane marker spacing and test pattern checking
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mk_cnt_r     <= 17'h00000;
         mk_lock_r    <= 1'b0;
         mk_err_ev_r  <= 1'b0;
         tp_err_ev_r  <= 1'b0;
         tp_errs_r    <= 16'h0000;
         rx_test_mode <= 1'b0;
      end else begin
         mk_err_ev_r <= 1'b0;
         tp_err_ev_r <= 1'b0;
         // Test mode follows the control bit
         rx_test_mode <= ctrl_r[`MTSR_CTRL_TEST];
         if (rx_rst | ~rx_decode_en) begin
            mk_cnt_r  <= 17'h00000;
            mk_lock_r <= 1'b0;
         end else if (rx_word_valid) begin
            // Marker due after spacing plus one words
            if (rx_word_is_marker) begin
               mk_cnt_r    <= 17'h00000;
               mk_lock_r   <= 1'b1;
               mk_err_ev_r <= mk_lock_r & (mk_cnt_r != mk_expect);
            end else begin
               mk_cnt_r    <= mk_cnt_r + 17'h00001;
               mk_err_ev_r <= mk_lock_r & (mk_cnt_r == mk_expect);
            end
         end
         if (wr_ctrl & ~hwdata[`MTSR_CTRL_TEST]) begin
            tp_errs_r <= 16'h0000;
         end else if (rx_test_mode & rx_tp_valid & ~rx_tp_idle_ok) begin
            tp_err_ev_r <= 1'b1;
            if (tp_errs_r != 16'hFFFF) begin
               tp_errs_r <= tp_errs_r + 16'h0001;
            end
         end
      end
   end

   // Receive stream with a four byte delay for FCS removal
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         en_eff_r         <= 1'b0;
         in_pkt_r         <= 1'b0;
         rx_len_r         <= 14'h0000;
         dl_fill_r        <= 3'h0;
         drain_r          <= 1'b0;
         out_started_r    <= 1'b0;
         err_pend_r       <= 1'b0;
         rx_in_ready      <= 1'b0;
         rx_decode_en     <= 1'b0;
         rx_out_valid     <= 1'b0;
         rx_out_data      <= 8'h00;
         rx_out_sop       <= 1'b0;
         rx_out_eop       <= 1'b0;
         rx_out_err       <= 1'b0;
         stat_rx_good_pkt <= 1'b0;
         stat_rx_bad_fcs  <= 1'b0;
         for (i = 0; i < 4; i = i + 1) begin
            dl_r[i] <= 8'h00;
         end
      end else begin
         rx_out_valid     <= 1'b0;
         rx_out_sop       <= 1'b0;
         rx_out_eop       <= 1'b0;
         rx_out_err       <= 1'b0;
         stat_rx_good_pkt <= 1'b0;
         stat_rx_bad_fcs  <= 1'b0;
         en_eff_r         <= en_eff_nxt & ~rx_rst;
         in_pkt_r         <= in_pkt_nxt;
         // Decoding stops once idle and disabled
         rx_decode_en     <= (en_eff_nxt | in_pkt_nxt | drain_nxt) & ~rx_rst;
         rx_in_ready      <= ~drain_nxt & ~rx_rst & (in_pkt_nxt | en_eff_nxt);
         if (rx_rst) begin
            rx_len_r      <= 14'h0000;
            dl_fill_r     <= 3'h0;
            drain_r       <= 1'b0;
            out_started_r <= 1'b0;
            err_pend_r    <= 1'b0;
         end else if (drain_r) begin
            // Flush held bytes, last one carries the end
            rx_out_valid  <= 1'b1;
            rx_out_data   <= dl_r[0];
            rx_out_sop    <= ~out_started_r;
            out_started_r <= ~drain_end;
            rx_out_eop    <= drain_end;
            rx_out_err    <= drain_end & err_pend_r;
            dl_fill_r     <= dl_fill_r - 3'h1;
            drain_r       <= ~drain_end;
            for (i = 0; i < 3; i = i + 1) begin
               dl_r[i] <= dl_r[i + 1];
            end
         end else if (rx_acc) begin
            rx_len_r <= eop_acc ? 14'h0000 : len_total;
            if (eop_acc) begin
               // Ignored errors still counted as good
               stat_rx_good_pkt <= ~rx_in_fcs_bad | ignore;
               stat_rx_bad_fcs  <= rx_in_fcs_bad;
            end
            if (strip & eop_acc) begin
               // Drop the three FCS bytes held and the incoming last one
               rx_out_valid  <= 1'b1;
               rx_out_data   <= dl_r[0];
               rx_out_sop    <= ~out_started_r;
               rx_out_eop    <= 1'b1;
               // Error flag on the final transfer
               rx_out_err    <= rx_in_fcs_bad & ~ignore;
               dl_fill_r     <= 3'h0;
               out_started_r <= 1'b0;
            end else begin
               err_pend_r <= eop_acc & rx_in_fcs_bad & ~ignore;
               drain_r    <= eop_acc;
               if (dl_fill_r == 3'h4) begin
                  rx_out_valid  <= 1'b1;
                  rx_out_data   <= dl_r[0];
                  rx_out_sop    <= ~out_started_r;
                  out_started_r <= 1'b1;
                  for (i = 0; i < 3; i = i + 1) begin
                     dl_r[i] <= dl_r[i + 1];
                  end
                  dl_r[3] <= rx_in_data;
               end else begin
                  for (i = 0; i < 4; i = i + 1) begin
                     if (dl_fill_r == i[2:0]) begin
                        dl_r[i] <= rx_in_data;
                     end
                  end
                  dl_fill_r <= dl_fill_r + 3'h1;
               end
            end
         end
      end
   end

endmodule // mtsr_core

// ==== testbench/mtsr_chk_props.sv ====
// Assertion checker for the transmit statistics and receive error outputs
`timescale 1ns/1ps
module mtsr_chk (
   input logic        sys_clk,
   input logic        reset,
   input logic        tx_pkt_end,
   input logic [13:0] tx_pkt_len,
   input logic        tx_pkt_fcs_err,
   input logic        tx_pkt_abort,
   input logic        tx_pkt_send,
   input logic        tx_pkt_drop,
   input logic        stat_tx_pkt_2048_4095,
   input logic        stat_tx_pkt_8192_9215,
   input logic        stat_tx_pkt_small,
   input logic        stat_tx_pkt_large,
   input logic        stat_tx_bad_fcs,
   input logic        stat_tx_frame_error,
   input logic        tx_lane_ready,
   input logic        stat_tx_local_fault,
   input logic        stat_tx_fifo_error,
   input logic        rx_out_valid,
   input logic        rx_out_eop,
   input logic        rx_out_err
);
   // One clock, idle in reset
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   chk_bin_low: assert property (
      tx_pkt_end && tx_pkt_len >= 14'd2048 && tx_pkt_len <= 14'd4095 |=> stat_tx_pkt_2048_4095)
      else $error("bin low");
   chk_bin_top: assert property (
      stat_tx_pkt_8192_9215 |-> $past(tx_pkt_end) && $past(tx_pkt_len) >= 14'd8192 && $past(tx_pkt_len) <= 14'd9215)
      else $error("bin top");
   chk_small_drop: assert property (
      tx_pkt_end && tx_pkt_len < 14'd64 |=> stat_tx_pkt_small && tx_pkt_drop && !tx_pkt_send)
      else $error("runt");
   chk_large_sent: assert property (
      tx_pkt_end && tx_pkt_len > 14'd9215 |=> stat_tx_pkt_large && tx_pkt_send)
      else $error("oversize");
   chk_bad_fcs: assert property (
      stat_tx_bad_fcs |-> $past(tx_pkt_end) && $past(tx_pkt_fcs_err) && $past(tx_pkt_len) > 14'd64)
      else $error("bad fcs");
   chk_frame_abort: assert property (
      tx_pkt_end && tx_pkt_abort |=> stat_tx_frame_error)
      else $error("abort");
   chk_fault_level: assert property (
      1'b1 |=> stat_tx_local_fault == !$past(tx_lane_ready))
      else $error("fault level");
   chk_fifo_sticky: assert property (
      $rose(stat_tx_fifo_error) |=> stat_tx_fifo_error [*8])
      else $error("fifo sticky");
   chk_pulse_cause: assert property (
      stat_tx_pkt_small || stat_tx_pkt_large || stat_tx_frame_error |-> $past(tx_pkt_end))
      else $error("pulse cause");
   chk_err_on_eop: assert property (
      rx_out_err |-> rx_out_eop && rx_out_valid)
      else $error("err off eop");

   // Scenarios
   cov_drop: cover property (tx_pkt_drop);
   cov_fifo: cover property ($rose(stat_tx_fifo_error));
   cov_rx_err: cover property (rx_out_err);
endmodule // mtsr_chk

bind mtsr_core mtsr_chk u_chk (.*);

// ==== testbench/mtsr_stat_model.sv ====
// Statistics counter model fed by the block's increment outputs
`timescale 1ns/1ps
module mtsr_stat_model (
   input  logic            sys_clk,
   input  logic            clr,
   input  logic [10:0]     stat,
   output logic [10:0][7:0] cnt
);
   // plain increment per high cycle, so a stretched pulse overcounts
   always @(posedge sys_clk) begin
      for (int i = 0; i < 11; i++) begin
         cnt[i] <= clr ? 8'h00 : cnt[i] + {7'h00, stat[i]};
      end
   end
endmodule // mtsr_stat_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the transmit statistics and receive control block
`timescale 1ns/1ps
`include "mtsr_defs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module testbench;
   logic sys_clk, reset, hsel, hwrite, tx_pkt_end, tx_pkt_fcs_err, tx_pkt_abort, tx_lane_ready, cc_push, cc_pop;
   logic rx_word_valid, rx_word_is_marker, rx_tp_valid, rx_tp_idle_ok, rx_in_valid, rx_in_eop, rx_in_fcs_bad;
   logic              cnt_clr, last_err;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [7:0]        rx_in_data, last_dat;
   logic [13:0]       tx_pkt_len;
   logic [31:0]       haddr, hwdata, q;
   logic [10:0][7:0]  cnt;
   logic [13:0]       lens [11] = '{63, 64, 65, 2047, 2048, 4095, 4096, 8191, 8192, 9215, 9216};
   int                miscompares, tests_run, nbytes;
   wire hready, hreadyout, hresp, irq, tx_pkt_send, tx_pkt_drop, stat_tx_pkt_2048_4095, stat_tx_pkt_4096_8191;
   wire stat_tx_pkt_8192_9215, stat_tx_pkt_small, stat_tx_pkt_large, stat_tx_bad_fcs, stat_tx_frame_error;
   wire stat_tx_local_fault, stat_tx_fifo_error, rx_decode_en, rx_test_mode, rx_in_ready, rx_out_valid;
   wire rx_out_sop, rx_out_eop, rx_out_err, stat_rx_good_pkt, stat_rx_bad_fcs;
   wire [7:0]  rx_out_data;
   wire [31:0] hrdata;

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;
   mtsr_core dut (.*);
   mtsr_stat_model u_cnt (
      .sys_clk (sys_clk),
      .clr     (cnt_clr),
      .stat    ({tx_pkt_send, tx_pkt_drop, stat_tx_pkt_2048_4095, stat_tx_pkt_4096_8191, stat_tx_pkt_8192_9215,
                 stat_tx_pkt_small, stat_tx_pkt_large, stat_tx_bad_fcs, stat_tx_frame_error, stat_rx_good_pkt,
                 stat_rx_bad_fcs}),
      .cnt     (cnt)
   );

   // 200 MHz core clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // User receive capture
   always @(posedge sys_clk) begin
      if (rx_out_valid === 1'b1) begin
         nbytes <= nbytes + 1;
         if (rx_out_eop === 1'b1) {last_err, last_dat} <= {rx_out_err, rx_out_data};
      end
   end

   // One word transfer, no assumed latency
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge sys_clk);
      {htrans, haddr, hwrite} <= {2'h2, 24'h0, a, w};
      do @(posedge sys_clk); while (hready !== 1'b1);
      {htrans, hwdata} <= {2'h0, d};
      do @(posedge sys_clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0, q);
   endtask

   // One packet report
   task automatic tx_rep(input logic [13:0] len, input logic fe, input logic ab);
      logic [8:0] exp;
      exp = {len >= `MTSR_LEN_MIN, len < `MTSR_LEN_MIN, len >= `MTSR_LEN_B2048 && len < `MTSR_LEN_B4096,
             len >= `MTSR_LEN_B4096 && len < `MTSR_LEN_B8192, len >= `MTSR_LEN_B8192 && len <= `MTSR_LEN_MAX,
             len < `MTSR_LEN_MIN, len > `MTSR_LEN_MAX, fe && len > `MTSR_LEN_MIN, ab};
      @(posedge sys_clk);
      {tx_pkt_end, tx_pkt_len, tx_pkt_fcs_err, tx_pkt_abort} <= {1'b1, len, fe, ab};
      @(posedge sys_clk);
      tx_pkt_end <= 1'b0;
      #1 `CHK({tx_pkt_send, tx_pkt_drop, stat_tx_pkt_2048_4095, stat_tx_pkt_4096_8191, stat_tx_pkt_8192_9215,
              stat_tx_pkt_small, stat_tx_pkt_large, stat_tx_bad_fcs, stat_tx_frame_error}, exp)
   endtask

   // Byte packet, held until accepted
   task automatic pkt(input int n, input logic bad);
      nbytes = 0;
      for (int i = 0; i < n; i++) begin
         {rx_in_valid, rx_in_data, rx_in_eop, rx_in_fcs_bad} <= {1'b1, i[7:0], i == n - 1, bad};
         do @(posedge sys_clk); while (rx_in_ready !== 1'b1);
      end
      rx_in_valid <= 1'b0;
      repeat (12) @(posedge sys_clk);
   endtask

   // Lane words, most significant bit first, one marks a marker
   task automatic words(input logic [4:0] s);
      for (int i = 4; i >= 0; i--) begin
         @(posedge sys_clk);
         {rx_word_valid, rx_word_is_marker} <= {1'b1, s[i]};
      end
      @(posedge sys_clk);
      rx_word_valid <= 1'b0;
   endtask

   // port reset after a compensation FIFO error
   task automatic rst_port();
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {reset, cnt_clr, tx_lane_ready, hsel, hsize, hwrite, htrans, haddr, hwdata} = {4'hF, 3'h2, 67'h0};
      {tx_pkt_end, tx_pkt_len, tx_pkt_fcs_err, tx_pkt_abort, cc_push, cc_pop} = '0;
      {rx_word_valid, rx_word_is_marker, rx_tp_valid, rx_tp_idle_ok, last_err} = '0;
      {rx_in_valid, rx_in_data, rx_in_eop, rx_in_fcs_bad} = '0;
      {miscompares, tests_run, nbytes} = '0;
      repeat (3) @(posedge sys_clk);
      {reset, cnt_clr} <= 2'b00;
      rd(`MTSR_OFF_CTRL);
      `CHK(q, 32'h1)
      rd(`MTSR_OFF_SPACING);
      `CHK(q, 32'h3FFF)
      rd(8'h40);
      `CHK({hresp, q}, 33'h0)
      // Length boundaries, then totals
      foreach (lens[i])
         tx_rep(lens[i], i[0], i == 3);
      @(posedge sys_clk);
      #1 `CHK(cnt, {8'd10, 8'd1, 8'd2, 8'd2, 8'd2, 8'd1, 8'd1, 8'd4, 8'd1, 8'd0, 8'd0})
      // Lane down keeps init
      @(posedge sys_clk);
      tx_lane_ready <= 1'b0;
      rd(`MTSR_OFF_STATUS);
      `CHK({stat_tx_local_fault, q[0]}, 2'b11)
      tx_lane_ready <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 `CHK(stat_tx_local_fault, 1'b0)
      // Sixteen pushes fit
      @(posedge sys_clk);
      cc_push <= 1'b1;
      repeat (16) @(posedge sys_clk);
      #1 `CHK(stat_tx_fifo_error, 1'b0)
      repeat (2) @(posedge sys_clk);
      cc_push <= 1'b0;
      #1 `CHK(stat_tx_fifo_error, 1'b1)
      wr(`MTSR_OFF_INT_MASK, 32'h1);
      @(posedge sys_clk);
      #1 `CHK(irq, 1'b1)
      wr(`MTSR_OFF_INT_MASK, 32'h0);
      @(posedge sys_clk);
      #1 `CHK(irq, 1'b0)
      rst_port();
      `CHK(stat_tx_fifo_error, 1'b0)
      // Empty pop underflows
      @(posedge sys_clk);
      cc_pop <= 1'b1;
      @(posedge sys_clk);
      cc_pop <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 `CHK(stat_tx_fifo_error, 1'b1)
      rst_port();
      // Settings only under receive reset
      wr(`MTSR_OFF_INT_MASK, 32'h8);
      wr(`MTSR_OFF_CTRL, 32'h15);
      wr(`MTSR_OFF_SPACING, 32'h2);
      wr(`MTSR_OFF_CTRL, 32'h5);
      pkt(10, 1'b1);
      `CHK(nbytes, 6)
      `CHK({last_err, irq, last_dat}, 10'h305)
      rd(`MTSR_OFF_INT_STAT);
      `CHK(q[3], 1'b1)
      wr(`MTSR_OFF_INT_STAT, 32'h8);
      @(posedge sys_clk);
      #1 `CHK(irq, 1'b0)
      // Ignored FCS error
      wr(`MTSR_OFF_CTRL, 32'hD);
      pkt(10, 1'b1);
      `CHK(last_err, 1'b0)
      `CHK(cnt[1:0], {8'd1, 8'd2})
      pkt(8, 1'b0);
      `CHK(nbytes, 8)
      wr(`MTSR_OFF_CTRL, 32'h19);
      wr(`MTSR_OFF_CTRL, 32'h9);
      pkt(10, 1'b0);
      `CHK(nbytes, 10)
      // Marker spacing good, then bad
      words(5'b10001);
      rd(`MTSR_OFF_INT_STAT);
      `CHK(q[1], 1'b0)
      words(5'b00100);
      rd(`MTSR_OFF_INT_STAT);
      `CHK(q[1], 1'b1)
      // Two bad test blocks
      wr(`MTSR_OFF_CTRL, 32'h3);
      @(posedge sys_clk);
      {rx_tp_valid, rx_tp_idle_ok} <= 2'b10;
      @(posedge sys_clk);
      rx_tp_idle_ok <= 1'b1;
      @(posedge sys_clk);
      rx_tp_idle_ok <= 1'b0;
      @(posedge sys_clk);
      rx_tp_valid <= 1'b0;
      #1 `CHK(rx_test_mode, 1'b1)
      rd(`MTSR_OFF_TP_ERRS);
      `CHK(q, 32'h2)
      // Receive disabled
      wr(`MTSR_OFF_CTRL, 32'h0);
      repeat (2) @(posedge sys_clk);
      #1 `CHK({rx_decode_en, rx_in_ready}, 2'b00)
      wrap_up();
   end

   // Watchdog
   initial begin
      #100000;
      miscompares++;
      wrap_up();
   end
endmodule // testbench
